//--- testbench/ips_sequencer_tb_top.sv
// self-checking bench for the ignition power sequencer
`timescale 1ns/1ps
module ips_sequencer_tb_top;
   import ips_pkg::*;
   localparam int T = 4;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e;} ips_row_t;
   logic        pclk = 1'h0;
   logic        presetn = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        key_in = 1'h0;
   logic        battery_overvoltage = 1'h0;
   logic        permanent_supply = 1'h0;
   logic        stuck_relay = 1'h0;
   wire  [31:0] prdata;
   wire         pready, pslverr, bvu, s5ok;
   wire         main_relay_drive, bias_enable, supply_5v_en, supply_3v3_en;
   wire         sensor_supplies_en, system_enable, reset_out_n;
   wire  [3:0]  injector_en;
   wire  [1:0]  starter_en;
   wire  [8:0]  obs;
   int          num_errors = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          t0;
   logic [31:0] rd;
   logic        er;
   ips_row_t    rows [10];
   assign obs = {starter_en === 2'h3, injector_en === 4'hf, reset_out_n, system_enable,
                 sensor_supplies_en, supply_3v3_en, supply_5v_en, bias_enable, main_relay_drive};
   ips_sequencer #(.TICK_CYCLES(T)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .key_in(key_in), .battery_not_undervoltage(bvu),
      .supply_5v_ok(s5ok), .battery_overvoltage(battery_overvoltage),
      .permanent_supply(permanent_supply), .main_relay_drive(main_relay_drive),
      .bias_enable(bias_enable), .supply_5v_en(supply_5v_en), .supply_3v3_en(supply_3v3_en),
      .sensor_supplies_en(sensor_supplies_en), .system_enable(system_enable),
      .reset_out_n(reset_out_n), .injector_en(injector_en), .starter_en(starter_en));
   ips_supply_model u_env (.pclk(pclk), .presetn(presetn), .main_relay_drive(main_relay_drive),
      .supply_5v_en(supply_5v_en), .permanent_supply(permanent_supply),
      .stuck_relay(stuck_relay), .battery_not_undervoltage(bvu), .supply_5v_ok(s5ok));
   initial begin
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
   end
   task automatic tally_and_finish();
      if (num_errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic in_range(input int v, input int lo, input int hi);
      check({31'h0, v >= lo && v <= hi}, 32'h1);
   endtask
   task automatic wait_bit(input int idx, input logic v, input int lim);
      int k;
      k = 0;
      while (obs[idx] !== v) begin
         if (k == lim) begin
            num_errors++;
            tally_and_finish();
         end
         @(posedge pclk);
         k++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
         if (k > 16) begin
            num_errors++;
            tally_and_finish();
         end
      end while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic power_up();
      key_in <= 1'h1;
      t0 = cyc;
      wait_bit(0, 1'h1, (KEY_FILT_TK + 8) * T);
      in_range(cyc - t0, KEY_FILT_TK * T, (KEY_FILT_TK + 2) * T + 12);
      check(obs[2:1], 2'h0);
      wait_bit(1, 1'h1, 32);
      t0 = cyc;
      wait_bit(2, 1'h1, (REG_DLY_TK + 4) * T);
      in_range(cyc - t0, (REG_DLY_TK - 1) * T, (REG_DLY_TK + 1) * T + 8);
      check(obs[4:3], 2'h2);
      t0 = cyc;
      wait_bit(3, 1'h1, (V33_DLY_TK + 6) * T);
      in_range(cyc - t0, (V33_DLY_TK - 1) * T, (V33_DLY_TK + 1) * T + 16);
      repeat (12) @(posedge pclk);
      check(obs[6:0], 7'h7f);
   endtask
   task automatic key_off_wait(input int lim);
      key_in <= 1'h0;
      t0 = cyc;
      wait_bit(0, 1'h0, lim);
   endtask
   initial begin
      rows = '{'{1'h0, OFS_CFG, 32'h0, 32'h01, 1'h0}, '{1'h0, OFS_DRV, 32'h0, 32'h00, 1'h0},
               '{1'h1, OFS_DRV, 32'hffffffff, 32'h0, 1'h0}, '{1'h0, OFS_DRV, 32'h0, 32'h3f, 1'h0},
               '{1'h1, OFS_CFG, 32'hffffffff, 32'h0, 1'h0}, '{1'h0, OFS_CFG, 32'h0, 32'h7f, 1'h0},
               '{1'h1, 8'h0c, 32'h1, 32'h0, 1'h1}, '{1'h0, 8'h0c, 32'h0, 32'h0, 1'h1},
               '{1'h1, OFS_CFG, 32'h01, 32'h0, 1'h0}, '{1'h1, OFS_DRV, 32'h0, 32'h0, 1'h0}};
      repeat (10) @(posedge pclk);
      check(obs, 9'h000);
      check(pready, 1'h0);
      presetn <= 1'h1;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         check(er, rows[i].e);
         if (!rows[i].w) check(rd, rows[i].r);
      end
      // short key pulse must not power up
      key_in <= 1'h1;
      repeat ((KEY_FILT_TK - 60) * T) @(posedge pclk);
      key_in <= 1'h0;
      repeat (20) @(posedge pclk);
      check(main_relay_drive, 1'h0);
      power_up();
      apb(1'h1, OFS_DRV, 32'h3f);
      key_in <= 1'h0;
      t0 = cyc;
      repeat (8) @(posedge pclk);
      apb(1'h0, OFS_STAT, 32'h0);
      check(rd[3:0], 4'he);
      check(obs[8:7], 2'h3);
      wait_bit(0, 1'h0, (KEY_FILT_TK + 8) * T);
      in_range(cyc - t0, KEY_FILT_TK * T, (KEY_FILT_TK + 2) * T + 12);
      check(obs[4:1], 4'h0);
      repeat (4) @(posedge pclk);
      check(injector_en, 4'h0);
      // power latch held, then released by software
      power_up();
      apb(1'h1, OFS_CFG, 32'h04);
      apb(1'h1, OFS_DRV, 32'h3f);
      key_in <= 1'h0;
      repeat ((KEY_FILT_TK + 40) * T) @(posedge pclk);
      check(obs[6:0], 7'h7f);
      check(injector_en, 4'h0);
      // key toggle while latched pulses reset low, supplies stay on
      key_in <= 1'h1;
      t0 = cyc;
      repeat (8) @(posedge pclk);
      check(reset_out_n, 1'h0);
      wait_bit(6, 1'h1, (TNL_TK + 4) * T);
      in_range(cyc - t0, (TNL_TK - 1) * T, (TNL_TK + 2) * T + 16);
      check(obs[2:0], 3'h7);
      key_in <= 1'h0;
      apb(1'h1, OFS_CFG, 32'h01);
      wait_bit(0, 1'h0, 64);
      // stay-on option, with and without a stuck relay
      for (int s = 1; s >= 0; s--) begin
         stuck_relay <= s[0];
         power_up();
         apb(1'h1, OFS_CFG, 32'h03);
         key_off_wait((KEY_FILT_TK + 8) * T);
         check(obs[6:1], 6'h2f);
         repeat (20) @(posedge pclk);
         if (s == 1) begin
            check(obs[6:1], 6'h2f);
            apb(1'h1, OFS_CFG, 32'h01);
            wait_bit(2, 1'h0, 16);
         end
         check(obs[4:1], 4'h0);
      end
      stuck_relay <= 1'h0;
      // overvoltage: a short excursion is filtered, a long one shuts down
      power_up();
      battery_overvoltage <= 1'h1;
      repeat ((OV_FILT_TK - 4) * T) @(posedge pclk);
      battery_overvoltage <= 1'h0;
      repeat (12) @(posedge pclk);
      check(main_relay_drive, 1'h1);
      battery_overvoltage <= 1'h1;
      t0 = cyc;
      wait_bit(0, 1'h0, (OV_FILT_TK + 4) * T + 16);
      in_range(cyc - t0, (OV_FILT_TK - 1) * T, (OV_FILT_TK + 4) * T + 16);
      battery_overvoltage <= 1'h0;
      key_in <= 1'h0;
      repeat ((KEY_FILT_TK + 20) * T) @(posedge pclk);
      // latch timeout, select code 1
      power_up();
      apb(1'h1, OFS_CFG, 32'h10);
      key_off_wait((KEY_FILT_TK + LT_STEP_TK + 8) * T);
      in_range(cyc - t0, (KEY_FILT_TK + LT_STEP_TK - 2) * T, (KEY_FILT_TK + LT_STEP_TK + 8) * T);
      // timed secure engine off under power latch
      power_up();
      apb(1'h1, OFS_CFG, 32'h08);
      apb(1'h1, OFS_DRV, 32'h3f);
      key_in <= 1'h0;
      t0 = cyc;
      repeat ((KEY_FILT_TK + 20) * T) @(posedge pclk);
      apb(1'h1, OFS_DRV, 32'h00);
      repeat (3) @(posedge pclk);
      check(injector_en, 4'h0);
      apb(1'h1, OFS_DRV, 32'h3f);
      repeat (3) @(posedge pclk);
      check(injector_en, 4'hf);
      wait_bit(7, 1'h0, (KEY_FILT_TK + SEO_TK + 8) * T);
      in_range(cyc - t0, (KEY_FILT_TK + SEO_TK - 2) * T, (KEY_FILT_TK + SEO_TK + 4) * T + 16);
      check(obs[8], 1'h1);
      check(obs[6:0], 7'h7f);
      t0 = cyc;
      wait_bit(8, 1'h0, (HOLD_TK + 4) * T + 16);
      in_range(cyc - t0, (HOLD_TK - 2) * T, (HOLD_TK + 4) * T + 16);
      apb(1'h1, OFS_CFG, 32'h09);
      wait_bit(0, 1'h0, 64);
      // permanent supply: bias follows the raw key level
      permanent_supply <= 1'h1;
      repeat (20) @(posedge pclk);
      key_in <= 1'h1;
      t0 = cyc;
      wait_bit(1, 1'h1, 40);
      check(obs[2], 1'h0);
      wait_bit(2, 1'h1, (KEY_FILT_TK + REG_DLY_TK + 8) * T);
      in_range(cyc - t0, (KEY_FILT_TK + REG_DLY_TK - 2) * T, (KEY_FILT_TK + REG_DLY_TK + 3) * T + 16);
      tally_and_finish();
   end
endmodule

//--- testbench/ips_supply_model.sv
// supply environment model: battery behind the relay and the 5 v comparator
`timescale 1ns/1ps
module ips_supply_model (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // from the sequencer
   input  wire logic main_relay_drive,
   input  wire logic supply_5v_en,
   // scenario controls
   input  wire logic permanent_supply,
   input  wire logic stuck_relay,
   // comparator outputs
   output logic      battery_not_undervoltage,
   output logic      supply_5v_ok
);
   logic [2:0] vb_r;
   logic [4:0] ok_r;
   // battery reaches the pin only through the relay unless wired permanently or stuck
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vb_r <= 3'h0;
      end else begin
         vb_r <= {vb_r[1:0], main_relay_drive | permanent_supply | stuck_relay};
      end
   end
   // the 5 v output ramps for a few cycles before its comparator reports good
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ok_r <= 5'h00;
      end else begin
         ok_r <= {ok_r[3:0], supply_5v_en & vb_r[2]};
      end
   end
   assign battery_not_undervoltage = vb_r[2];
   assign supply_5v_ok             = ok_r[4];
endmodule

//--- verilog/ips_pkg.sv
// constants for the ignition power sequencer
package ips_pkg;
   // apb register byte offsets
   localparam logic [7:0] OFS_CFG  = 8'h00;
   localparam logic [7:0] OFS_DRV  = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   // config_register_six fields
   localparam int CFG_REL_N  = 0;
   localparam int CFG_REGULATORS_STAY_ON_OPTION  = 1;
   localparam int CFG_TGL    = 2;
   localparam int CFG_SEO    = 3;
   localparam int CFG_SEL_LO = 4;
   localparam logic [6:0] CFG_RST = 7'h01;
   // driver command fields
   localparam int DRV_ST_LO = 4;
   localparam logic [5:0] DRV_RST = 6'h00;
   // status fields
   localparam int ST_KEY_RAW = 0;
   localparam int ST_KEY_FLT = 1;
   localparam int ST_LT_OK   = 2;
   localparam int ST_SYS_EN  = 3;
   localparam int ST_OV      = 4;
   localparam int ST_INJ_BLK = 5;
   localparam int ST_ST_BLK  = 6;
   localparam int ST_TNL     = 7;
   // clock and oscillator tick
   localparam int CLK_NS   = 8;
   localparam int TICK_NS  = 100000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   // times in microseconds, counts in oscillator ticks
   localparam int KEY_FILT_US = 16000;
   localparam int KEY_FILT_TK = KEY_FILT_US * 1000 / TICK_NS;
   localparam int REG_DLY_US  = 1000;
   localparam int REG_DLY_TK  = REG_DLY_US * 1000 / TICK_NS;
   localparam int V33_DLY_US  = 1000;
   localparam int V33_DLY_TK  = V33_DLY_US * 1000 / TICK_NS;
   localparam int SEO_US      = 225000;
   localparam int SEO_TK      = SEO_US * 1000 / TICK_NS;
   localparam int HOLD_US     = 100000;
   localparam int HOLD_TK     = HOLD_US * 1000 / TICK_NS;
   localparam int OV_FILT_US  = 1000;
   localparam int OV_FILT_TK  = OV_FILT_US * 1000 / TICK_NS;
   localparam int TNL_US      = 10000;
   localparam int TNL_TK      = TNL_US * 1000 / TICK_NS;
   // latch timeout step per select code, code 0 disables
   localparam int LT_STEP_US  = 1000000;
   localparam int LT_STEP_TK  = LT_STEP_US / (TICK_NS / 1000);
   typedef enum logic [2:0] {
      S_OFF, S_WAIT_VB, S_BIAS_DLY, S_WAIT_5V, S_RUN, S_REG_HOLD
   } ips_state_t;
endpackage

//--- verilog/ips_sequencer.sv
// ignition power sequencer with apb register access
`timescale 1ns/1ps
// Overview of operation
// - filtered key high powers up; main relay drive turns on before 5 V, 3.3 V and sensors
// - relay mode: biasing only after battery leaves undervoltage
// - 5 V and sensors after start delay; 3.3 V 1.0 ms after 5 V good
// - permanent supply: bias on raw key; 5 V delay after key filter
// - enable = (key or latch held and not timed out) and battery good
// - key low with latch released shuts down after the filter time
// - latch held keeps running until software releases it or the selected latch timeout expires
// - latch timeout forces shutdown; 3-bit select enables and sizes it
// - status shows raw key level and filtered key level
// - all supply outputs switch off at the same moment
// - stay-on option 0 drops regulators with relay; 1 keeps them
// - stay-on 1: regulators run until battery undervoltage or software clears the option
// - key low transition disables injectors and starters, overriding latch
// - only four injectors and two starters are affected
// - starters off only if condition persists after the hold delay
// - oscillator timer from key fall blocks stages after 225 ms
// - software still switches drivers during the interval; config selects mode
// - battery overvoltage held past its filter time shuts down
// - latch toggle option: key rise during latch pulses reset low
module ips_sequencer
   import ips_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // comparator and strap inputs
   input  wire logic        key_in,
   input  wire logic        battery_not_undervoltage,
   input  wire logic        supply_5v_ok,
   input  wire logic        battery_overvoltage,
   input  wire logic        permanent_supply,
   // supply and relay outputs
   output logic             main_relay_drive,
   output logic             bias_enable,
   output logic             supply_5v_en,
   output logic             supply_3v3_en,
   output logic             sensor_supplies_en,
   output logic             system_enable,
   output logic             reset_out_n,
   // power stage enables
   output logic      [3:0]  injector_en,
   output logic      [1:0]  starter_en
);
   logic [4:0]  sy1_r, sy2_r, sy3_r, inq_r;
   logic        key_raw, bat_ok, v5_ok, ov_raw, perm, key_prev_r, tick_r;
   logic        key_flt_r, flt_prev_r, rel_n, regulators_stay_on_option, lt_ok, ov_flt_r, sys_en, shut;
   logic        seo_on_r, inj_blk_r, st_blk_r, wr_en, acc, hit;
   logic [15:0] div_r;
   logic [8:0]  kf_cnt_r;
   logic [6:0]  cfg_r;
   logic [5:0]  drv_r;
   logic [2:0]  lt_sel;
   logic [17:0] lt_cnt_r, lt_lim;
   logic [7:0]  ov_cnt_r, tnl_cnt_r, stat;
   ips_state_t  state_r;
   logic [11:0] seq_cnt_r, seo_cnt_r;
   logic [31:0] rd_nxt;
   // three-stage synchronisers, level taken when stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sy1_r <= 5'h00;
         sy2_r <= 5'h00;
         sy3_r <= 5'h00;
         inq_r <= 5'h00;
      end else begin
         sy1_r <= {permanent_supply, battery_overvoltage, supply_5v_ok,
                   battery_not_undervoltage, key_in};
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
         inq_r <= (sy2_r & sy3_r) | (inq_r & (sy2_r | sy3_r));
      end
   end
   assign key_raw = inq_r[0];
   assign bat_ok  = inq_r[1];
   assign v5_ok   = inq_r[2];
   assign ov_raw  = inq_r[3];
   assign perm    = inq_r[4];

   // oscillator tick divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r  <= 16'h0000;
         tick_r <= 1'b0;
      end else if (div_r == 16'(TICK_CYCLES - 1)) begin
         div_r  <= 16'h0000;
         tick_r <= 1'b1;
      end else begin
         div_r  <= div_r + 16'h0001;
         tick_r <= 1'b0;
      end
   end

   // key deglitch filter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         kf_cnt_r   <= 9'h000;
         key_flt_r  <= 1'b0;
         flt_prev_r <= 1'b0;
         key_prev_r <= 1'b0;
      end else begin
         flt_prev_r <= key_flt_r;
         key_prev_r <= key_raw;
         if (key_raw == key_flt_r) begin
            kf_cnt_r <= 9'h000;
         end else if (tick_r) begin
            if (kf_cnt_r == 9'(KEY_FILT_TK - 1)) begin
               key_flt_r <= key_raw;
               kf_cnt_r  <= 9'h000;
            end else begin
               kf_cnt_r <= kf_cnt_r + 9'h001;
            end
         end
      end
   end

   // apb slave, answer one cycle after setup
   assign acc   = psel & penable & pready;
   assign wr_en = acc & pwrite;
   assign hit   = (paddr == OFS_CFG) | (paddr == OFS_DRV) | (paddr == OFS_STAT);
   assign stat  = {tnl_cnt_r != 8'h00, st_blk_r, inj_blk_r, ov_flt_r,
                   system_enable, lt_ok, key_flt_r, key_raw};

   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (paddr)
         OFS_CFG:  rd_nxt = {25'h0, cfg_r};
         OFS_DRV:  rd_nxt = {26'h0, drv_r};
         OFS_STAT: rd_nxt = {24'h0, stat};
         default:  rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
         prdata  <= (psel & ~penable & ~pwrite) ? rd_nxt : 32'h0000_0000;
      end
   end

   // config_register_six and driver commands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= CFG_RST;
         drv_r <= DRV_RST;
      end else if (wr_en) begin
         if (paddr == OFS_CFG) begin
            cfg_r <= pwdata[6:0];
         end
         if (paddr == OFS_DRV) begin
            drv_r <= pwdata[5:0];
         end
      end
   end
   assign rel_n  = cfg_r[CFG_REL_N];
   assign regulators_stay_on_option  = cfg_r[CFG_REGULATORS_STAY_ON_OPTION];
   assign lt_sel = cfg_r[CFG_SEL_LO +: 3];

   // latch timeout, code times step, code 0 disables
   assign lt_lim = 18'(32'(lt_sel) * LT_STEP_TK);
   assign lt_ok  = (lt_sel == 3'h0) | (lt_cnt_r < lt_lim);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lt_cnt_r <= 18'h00000;
      end else if (rel_n | key_flt_r) begin
         lt_cnt_r <= 18'h00000;
      end else if (tick_r & lt_ok & (lt_sel != 3'h0)) begin
         lt_cnt_r <= lt_cnt_r + 18'h00001;
      end
   end

   // battery overvoltage filter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ov_cnt_r <= 8'h00;
         ov_flt_r <= 1'b0;
      end else if (!ov_raw) begin
         ov_cnt_r <= 8'h00;
         ov_flt_r <= 1'b0;
      end else if (tick_r & !ov_flt_r) begin
         if (ov_cnt_r == 8'(OV_FILT_TK - 1)) begin
            ov_flt_r <= 1'b1;
         end else begin
            ov_cnt_r <= ov_cnt_r + 8'h01;
         end
      end
   end

   assign sys_en = ((~rel_n & lt_ok) | key_flt_r) & bat_ok;
   assign shut   = ~sys_en | ov_flt_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         system_enable <= 1'b0;
      end else begin
         system_enable <= sys_en;
      end
   end

   // power sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r            <= S_OFF;
         seq_cnt_r          <= 12'h000;
         main_relay_drive   <= 1'b0;
         bias_enable        <= 1'b0;
         supply_5v_en       <= 1'b0;
         supply_3v3_en      <= 1'b0;
         sensor_supplies_en <= 1'b0;
      end else begin
         case (state_r)
            S_OFF: begin
               bias_enable <= perm & (key_raw | key_flt_r);
               seq_cnt_r   <= 12'h000;
               if (key_flt_r) begin
                  main_relay_drive <= 1'b1;
                  state_r          <= S_WAIT_VB;
               end
            end
            S_WAIT_VB: begin
               if (!key_flt_r) begin
                  main_relay_drive <= 1'b0;
                  bias_enable      <= 1'b0;
                  state_r          <= S_OFF;
               end else if (perm | bat_ok) begin
                  bias_enable <= 1'b1;
                  state_r     <= S_BIAS_DLY;
               end
            end
            S_BIAS_DLY, S_WAIT_5V, S_RUN: begin
               if (shut) begin
                  main_relay_drive <= 1'b0;
                  seq_cnt_r        <= 12'h000;
                  if (regulators_stay_on_option & supply_5v_en) begin
                     state_r <= S_REG_HOLD;
                  end else begin
                     bias_enable        <= 1'b0;
                     supply_5v_en       <= 1'b0;
                     supply_3v3_en      <= 1'b0;
                     sensor_supplies_en <= 1'b0;
                     state_r            <= S_OFF;
                  end
               end else if (state_r == S_BIAS_DLY) begin
                  if (tick_r) begin
                     seq_cnt_r <= seq_cnt_r + 12'h001;
                  end
                  if (seq_cnt_r == 12'(REG_DLY_TK)) begin
                     supply_5v_en       <= 1'b1;
                     sensor_supplies_en <= 1'b1;
                     seq_cnt_r          <= 12'h000;
                     state_r            <= S_WAIT_5V;
                  end
               end else if (state_r == S_WAIT_5V) begin
                  if (!v5_ok) begin
                     seq_cnt_r <= 12'h000;
                  end else if (seq_cnt_r == 12'(V33_DLY_TK)) begin
                     supply_3v3_en <= 1'b1;
                     state_r       <= S_RUN;
                  end else if (tick_r) begin
                     seq_cnt_r <= seq_cnt_r + 12'h001;
                  end
               end
            end
            S_REG_HOLD: begin
               if (!bat_ok | !regulators_stay_on_option) begin
                  bias_enable        <= 1'b0;
                  supply_5v_en       <= 1'b0;
                  supply_3v3_en      <= 1'b0;
                  sensor_supplies_en <= 1'b0;
                  state_r            <= S_OFF;
               end
            end
            default: begin
               state_r <= S_OFF;
            end
         endcase
      end
   end

   // reset output: power down, 5 V undervoltage, key toggle pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tnl_cnt_r   <= 8'h00;
         reset_out_n <= 1'b0;
      end else begin
         if (cfg_r[CFG_TGL] & ~rel_n & ~key_flt_r & (state_r == S_RUN)
             & key_raw & ~key_prev_r) begin
            tnl_cnt_r <= 8'(TNL_TK);
         end else if (tick_r & (tnl_cnt_r != 8'h00)) begin
            tnl_cnt_r <= tnl_cnt_r - 8'h01;
         end
         reset_out_n <= supply_5v_en & v5_ok & (tnl_cnt_r == 8'h00)
                        & (state_r != S_OFF);
      end
   end

   // secure engine off timer and stage blocking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seo_on_r  <= 1'b0;
         seo_cnt_r <= 12'h000;
         inj_blk_r <= 1'b0;
         st_blk_r  <= 1'b0;
      end else if (key_flt_r) begin
         seo_on_r  <= 1'b0;
         seo_cnt_r <= 12'h000;
         inj_blk_r <= 1'b0;
         st_blk_r  <= 1'b0;
      end else if (flt_prev_r) begin
         seo_on_r  <= 1'b1;
         seo_cnt_r <= 12'h000;
         inj_blk_r <= ~cfg_r[CFG_SEO];
      end else if (seo_on_r & tick_r) begin
         if (seo_cnt_r == 12'(SEO_TK - 1)) begin
            inj_blk_r <= 1'b1;
         end
         if (seo_cnt_r == 12'(SEO_TK + HOLD_TK - 1)) begin
            st_blk_r <= 1'b1;
            seo_on_r <= 1'b0;
         end else begin
            seo_cnt_r <= seo_cnt_r + 12'h001;
         end
      end
   end
   // only injectors and starters are gated
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         injector_en <= 4'h0;
         starter_en  <= 2'h0;
      end else begin
         injector_en <= drv_r[3:0] & {4{~inj_blk_r}};
         starter_en  <= drv_r[DRV_ST_LO +: 2] & {2{~st_blk_r}};
      end
   end
   // checks
   a_relay_first: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(main_relay_drive) |-> !supply_5v_en && !supply_3v3_en && !sensor_supplies_en)
      else $error("relay not first");
   a_bias_after_vb: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(bias_enable) && !perm |-> $past(bat_ok))
      else $error("bias before battery good");
   a_v33_after_5v: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(supply_3v3_en) |-> supply_5v_en && $past(v5_ok, 2))
      else $error("3v3 before 5v good");
   a_enable_uv: assert property (@(posedge pclk) disable iff (!presetn)
      !bat_ok |=> !system_enable)
      else $error("enable with battery low");
   a_latch_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == S_RUN && !rel_n && lt_ok && bat_ok && !ov_flt_r |=> state_r == S_RUN)
      else $error("latch did not hold");
   a_offs_together: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(supply_5v_en) |-> !supply_3v3_en && !sensor_supplies_en && !bias_enable)
      else $error("supplies not off together");
   a_regulators_stay_on_option_clear: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(main_relay_drive) && !$past(regulators_stay_on_option) && $past(state_r) != S_WAIT_VB
      |-> !supply_5v_en)
      else $error("regulators left on");
   a_hold_regs: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == S_REG_HOLD |-> !main_relay_drive && supply_5v_en)
      else $error("hold state wrong");
   a_inj_block: assert property (@(posedge pclk) disable iff (!presetn)
      inj_blk_r |=> injector_en == 4'h0)
      else $error("injector not blocked");
   a_key_filter: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(key_flt_r) |-> $past(kf_cnt_r) == 9'(KEY_FILT_TK - 1))
      else $error("key filter early");
   a_starter_late: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(st_blk_r) |-> inj_blk_r && !key_flt_r)
      else $error("starter blocked early");

   c_run: cover property (@(posedge pclk) disable iff (!presetn) state_r == S_RUN);
   c_hold: cover property (@(posedge pclk) disable iff (!presetn) state_r == S_REG_HOLD);
   c_tnl: cover property (@(posedge pclk) disable iff (!presetn) $rose(tnl_cnt_r != 8'h00));
   c_seo: cover property (@(posedge pclk) disable iff (!presetn) $rose(st_blk_r));
endmodule
